// ---- tb/dzcg_cpu_model.sv ----
// Purpose: CPU side model that counts slowed enables and asks for peripheral writes.
// Assumes: A peripheral write is requested on every executed CPU cycle.
// Notes: The tick count is two-state and is only used as a difference.
`timescale 1ns/100ps
module dzcg_cpu_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	output logic [7:0] wr_out,
	output int ticks_out
);
	initial wr_out = 8'h00;
	always @(posedge clk_in) begin
		wr_out <= {8{ce_in & rstn_in}};
		ticks_out <= rstn_in ? ticks_out + ce_in : 0;
	end
endmodule

// ---- tb/dzcg_props.sv ----
// Purpose: Port checks for the doze and clock gate block.
// Assumes: One clock; presence straps held steady.
// Notes: Bound from the bench top.
`timescale 1ns/100ps
`include "dzcg_cfg.svh"
module dzcg_props (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic [7:0] PRESENT_IN,
	input wire logic [7:0] PERIPH_WR_IN,
	input wire logic CPU_CE_OUT,
	input wire logic PERIPH_CE_OUT,
	input wire logic [7:0] PERIPH_CLK_EN_OUT,
	input wire logic [7:0] PERIPH_WR_EN_OUT,
	input wire logic [7:0] PERIPH_RD_VALID_OUT
);
	logic gw;
	assign gw = WR_IN && ADDR_IN == `DZCG_OFF_GATE;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	sequence rel2;
		$rose(RSTN_IN) ##2 1'b1;
	endsequence
	property gate_lag;
		logic [7:0] v;
		(gw, v = ~WDATA_IN[7:0]) ##1 !gw |-> ##1 PERIPH_CLK_EN_OUT == (v & PRESENT_IN);
	endproperty
	a_per_full: assert property ($past(RSTN_IN) |-> PERIPH_CE_OUT)
		else $error("peripheral enable low");
	a_cpu_sync: assert property (CPU_CE_OUT |-> PERIPH_CE_OUT)
		else $error("cpu enable alone");
	a_reset_full: assert property ($rose(RSTN_IN) |-> ##1 CPU_CE_OUT [*2])
		else $error("cpu slow after reset");
	a_gate_reset: assert property (rel2 |-> PERIPH_CLK_EN_OUT == PRESENT_IN)
		else $error("gate reset");
	a_gate_lag: assert property (gate_lag)
		else $error("gate lag");
	a_write_gated: assert property (
		$past(RSTN_IN) |-> PERIPH_WR_EN_OUT == ($past(PERIPH_WR_IN) & PERIPH_CLK_EN_OUT))
		else $error("write while gated");
	a_read_valid: assert property (
		$past(RSTN_IN, 2) |-> PERIPH_RD_VALID_OUT == PERIPH_CLK_EN_OUT)
		else $error("read valid");
	a_present_only: assert property (
		$past(RSTN_IN, 2) |-> (PERIPH_CLK_EN_OUT & ~PRESENT_IN) == 8'h00)
		else $error("absent peripheral on");
endmodule

// ---- tb/dzcg_top_tb.sv ----
// Purpose: Self-checking bench for the doze and clock gate block.
// Assumes: Peripheral 7 is absent on this variant.
// Notes: Windows are whole divider periods, so pulse counts are exact.
`timescale 1ns/100ps
module dzcg_top_tb;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, irq = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	logic cpu_ce, osc_ce;
	logic [7:0] pwr, clk_en, wr_en, rd_v;
	int n_fail = 0, checked = 0, cyc = 0, ticks, oscs = 0;
	always #10 clk = ~clk;
	dzcg_top dzcg_top_i (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .IRQ_IN(irq), .PRESENT_IN(8'h7F), .PERIPH_WR_IN(pwr),
		.RDATA_OUT(rdata), .CPU_CE_OUT(cpu_ce), .PERIPH_CE_OUT(), .OSC_CE_OUT(osc_ce),
		.PERIPH_CLK_EN_OUT(clk_en), .PERIPH_WR_EN_OUT(wr_en), .PERIPH_RD_VALID_OUT(rd_v));
	dzcg_cpu_model dzcg_cpu_model_i (.clk_in(clk), .rstn_in(rstn), .ce_in(cpu_ce),
		.wr_out(pwr), .ticks_out(ticks));
	task close_out;
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		oscs <= oscs + osc_ce;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			close_out;
		end
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("register %h", a), e, rdata);
	endtask
	task irq_pulse;
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
	endtask
	task t_reset;
		rreg(4'h0, 16'h3040);
		rreg(4'h4, 16'h0000);
		rreg(4'hC, 16'h007F);
		rreg(4'h8, 16'h0000);
	endtask
	// Every ratio is tried with the fast RC postscale set to the same code.
	task t_ratio;
		int t0, f0;
		for (int r = 0; r < 8; r++) begin
			wreg(4'h0, 16'(r << 12 | r << 8) | 16'h0840);
			rreg(4'h0, 16'(r << 12 | r << 8) | (r > 0 ? 16'h0840 : 16'h0040));
			repeat ((1 << r) + 4) @(posedge clk);
			#1;
			t0 = ticks;
			f0 = oscs;
			repeat (4 << r) @(posedge clk);
			#1;
			chk("cpu ticks", 16'h0004, 16'(ticks - t0));
			chk("fast rc ticks", 16'h0004, 16'(oscs - f0));
			wreg(4'h0, 16'h0000);
		end
	endtask
	task t_irq;
		wreg(4'h0, 16'h3840);
		rreg(4'h8, 16'h0001);
		wreg(4'h0, 16'h5840);
		irq_pulse;
		rreg(4'h0, 16'h3840);
		wreg(4'h0, 16'hB840);
		irq_pulse;
		rreg(4'h0, 16'hB040);
		rreg(4'h8, 16'h0000);
	endtask
	task t_gate;
		wreg(4'h4, 16'h00A5);
		#1;
		chk("enables early", 16'h007F, {8'h00, clk_en});
		@(posedge clk);
		#1;
		chk("enables", 16'h005A, {8'h00, clk_en});
		chk("writes", 16'h005A, {8'h00, wr_en});
		chk("read valid", 16'h005A, {8'h00, rd_v});
		rreg(4'hC, 16'h005A);
		wreg(4'h4, 16'h0000);
		@(posedge clk);
		#1;
		chk("enables again", 16'h007F, {8'h00, clk_en});
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_ratio;
		t_irq;
		t_gate;
		close_out;
	end
endmodule
bind dzcg_top dzcg_props dzcg_props_i (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN),
	.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .PRESENT_IN(PRESENT_IN), .PERIPH_WR_IN(PERIPH_WR_IN),
	.CPU_CE_OUT(CPU_CE_OUT), .PERIPH_CE_OUT(PERIPH_CE_OUT),
	.PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT), .PERIPH_WR_EN_OUT(PERIPH_WR_EN_OUT),
	.PERIPH_RD_VALID_OUT(PERIPH_RD_VALID_OUT));

// ---- verilog/dzcg_cfg.svh ----
// Purpose: Offsets, field positions, reset values and counts for the doze and clock gate block.
// Assumes: Byte addresses on a plain register port, one 16-bit register per word.
// Notes: Definitions only.
`ifndef DZCG_CFG_SVH
`define DZCG_CFG_SVH

// ********************
// Register offsets
// ********************
`define DZCG_ADDR_W 4
`define DZCG_OFF_DIV_CTRL 4'h0
`define DZCG_OFF_GATE 4'h4
`define DZCG_OFF_STATUS 4'h8
`define DZCG_OFF_PRESENT 4'hC

// ********************
// Field positions
// ********************
`define DZCG_BIT_RECOVER 15
`define DZCG_RATIO_HI 14
`define DZCG_RATIO_LO 12
`define DZCG_BIT_SLOWEN 11
`define DZCG_POSTSC_HI 10
`define DZCG_POSTSC_LO 8
`define DZCG_PLLOUT_HI 7
`define DZCG_PLLOUT_LO 6
`define DZCG_PLLIN_HI 4
`define DZCG_PLLIN_LO 0

// ********************
// Reset values and counts
// ********************
`define DZCG_CTRL_RESET 16'h3040
`define DZCG_CTRL_WMASK 16'h87DF
`define DZCG_NUM_PERIPH 8
`define DZCG_PRESENT_DEFAULT 8'hFF
`define DZCG_RATIO_NONE 3'h0
`define DZCG_GATE_DELAY 1

`endif

// ---- verilog/dzcg_divider.sv ----
// Purpose: Counts system cycles and pulses the CPU enable once per selected ratio.
// Assumes: One system clock; ratio given as a power-of-two exponent.
// Notes: Counter restarts whenever slow-down is off, so the first slow pulse is aligned.
`timescale 1ns/100ps
module dzcg_divider (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic [2:0] ratio_in,
	output logic tick_out
);

	logic [6:0] cnt_r;
	logic [6:0] limit;

	// ********************
	// Cycle counter
	// ********************
	assign limit = 7'((8'h01 << ratio_in) - 8'h01);

	always_ff @(posedge clk_in) begin
		if (!rstn_in || !slow_in || cnt_r >= limit) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_r + 7'h01;
		end
	end

	// Pulse every cycle at 1:1, otherwise once per 2^ratio cycles.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			tick_out <= 1'b1;
		end else begin
			tick_out <= !slow_in || (cnt_r >= limit);
		end
	end

endmodule

// ---- verilog/dzcg_pkg.sv ----
// Purpose: Types shared by the doze and clock gate block.
// Assumes: Constants come from dzcg_cfg.svh.
// Notes: Types only.
package dzcg_pkg;

	// ********************
	// Bus request carrier
	// ********************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} dzcg_req_t;

	typedef enum logic [0:0] {
		DZCG_FULL,
		DZCG_SLOW
	} dzcg_speed_t;

endpackage

// ---- verilog/dzcg_top.sv ----
// Purpose: Clock divisor control with doze slow-down and per-peripheral clock gating.
// Assumes: One 50 MHz clock; clock slow-down is expressed as one-cycle enable pulses.
// Notes: Registers sit on a plain port with read data one cycle after the strobe.
`timescale 1ns/100ps
`include "dzcg_cfg.svh"
module dzcg_top (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic IRQ_IN,
	input wire logic [7:0] PRESENT_IN,
	input wire logic [7:0] PERIPH_WR_IN,
	output logic [15:0] RDATA_OUT,
	output logic CPU_CE_OUT,
	output logic PERIPH_CE_OUT,
	output logic OSC_CE_OUT,
	output logic [7:0] PERIPH_CLK_EN_OUT,
	output logic [7:0] PERIPH_WR_EN_OUT,
	output logic [7:0] PERIPH_RD_VALID_OUT
);

	dzcg_pkg::dzcg_req_t req;
	dzcg_pkg::dzcg_speed_t speed_r;
	logic recover_r;
	logic [2:0] ratio_r;
	logic slowen_r;
	logic [2:0] postscale_r;
	logic [1:0] pll_out_div_r;
	logic [4:0] pll_in_pre_r;
	logic [7:0] gate_r;
	logic [7:0] run_r;
	logic [7:0] run_nxt;
	logic [7:0] postscale_cnt_r;
	logic [7:0] postscale_limit;
	logic postscale_wrap;
	logic [15:0] ctrl_word;
	logic [15:0] gate_word;
	logic [15:0] status_word;
	logic [15:0] run_word;
	logic [15:0] rd_word;
	logic wr_ctrl;
	logic wr_gate;
	logic irq_recover;
	logic [2:0] ratio_nxt;
	logic slowen_nxt;
	logic cpu_tick;

	// ********************
	// Bus decode
	// ********************
	assign req = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, wdata: WDATA_IN};
	assign wr_ctrl = req.wr && req.addr == `DZCG_OFF_DIV_CTRL;
	assign wr_gate = req.wr && req.addr == `DZCG_OFF_GATE;

	// ********************
	// Recovery on interrupt
	// ********************
	// Only a set recover bit lets an interrupt reach the slow-down enable.
	assign irq_recover = recover_r && IRQ_IN;

	// ********************
	// Control register
	// ********************
	always_comb begin
		ratio_nxt = ratio_r;
		slowen_nxt = slowen_r;
		if (wr_ctrl) begin
			if (!slowen_r) begin
				ratio_nxt = req.wdata[`DZCG_RATIO_HI:`DZCG_RATIO_LO];
			end
			// The ratio that holds after this write is checked, so a combined write works.
			slowen_nxt = req.wdata[`DZCG_BIT_SLOWEN] && ratio_nxt != `DZCG_RATIO_NONE;
		end
		// The interrupt wins over a software set in the same cycle; recovery is the priority.
		if (irq_recover) begin
			slowen_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ratio_r <= 3'(`DZCG_CTRL_RESET >> `DZCG_RATIO_LO);
		end else begin
			ratio_r <= ratio_nxt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			slowen_r <= 1'b0;
		end else begin
			slowen_r <= slowen_nxt;
		end
	end

	// ********************
	// Stored fields
	// ********************
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			recover_r <= 1'(`DZCG_CTRL_RESET >> `DZCG_BIT_RECOVER);
		end else if (wr_ctrl) begin
			recover_r <= req.wdata[`DZCG_BIT_RECOVER];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			postscale_r <= 3'(`DZCG_CTRL_RESET >> `DZCG_POSTSC_LO);
		end else if (wr_ctrl) begin
			postscale_r <= req.wdata[`DZCG_POSTSC_HI:`DZCG_POSTSC_LO];
		end
	end

	// The PLL fields are only stored; the PLL itself lies outside this block.
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			pll_out_div_r <= 2'(`DZCG_CTRL_RESET >> `DZCG_PLLOUT_LO);
		end else if (wr_ctrl) begin
			pll_out_div_r <= req.wdata[`DZCG_PLLOUT_HI:`DZCG_PLLOUT_LO];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			pll_in_pre_r <= 5'(`DZCG_CTRL_RESET >> `DZCG_PLLIN_LO);
		end else if (wr_ctrl) begin
			pll_in_pre_r <= req.wdata[`DZCG_PLLIN_HI:`DZCG_PLLIN_LO];
		end
	end

	// ********************
	// Speed status
	// ********************
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			speed_r <= dzcg_pkg::DZCG_FULL;
		end else begin
			speed_r <= slowen_r ? dzcg_pkg::DZCG_SLOW : dzcg_pkg::DZCG_FULL;
		end
	end

	// ********************
	// Module disable bits
	// ********************
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			gate_r <= 8'h00;
		end else if (wr_gate) begin
			gate_r <= req.wdata[7:0];
		end
	end

	// A stored disable bit reaches the modules at the next edge, one cycle after the write.
	assign run_nxt = ~gate_r & PRESENT_IN;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			run_r <= 8'h00;
		end else begin
			run_r <= run_nxt;
		end
	end

	// ********************
	// Peripheral enables
	// ********************
	// Each control has its own flop, so a disabled module sees all three fall together.
	genvar g;
	generate
		for (g = 0; g < `DZCG_NUM_PERIPH; g = g + 1) begin : gen_gate
			always_ff @(posedge CLK_IN) begin
				if (!RSTN_IN) begin
					PERIPH_CLK_EN_OUT[g] <= 1'b0;
				end else begin
					PERIPH_CLK_EN_OUT[g] <= run_nxt[g];
				end
			end

			always_ff @(posedge CLK_IN) begin
				if (!RSTN_IN) begin
					PERIPH_WR_EN_OUT[g] <= 1'b0;
				end else begin
					PERIPH_WR_EN_OUT[g] <= run_nxt[g] && PERIPH_WR_IN[g];
				end
			end

			always_ff @(posedge CLK_IN) begin
				if (!RSTN_IN) begin
					PERIPH_RD_VALID_OUT[g] <= 1'b0;
				end else begin
					PERIPH_RD_VALID_OUT[g] <= run_nxt[g];
				end
			end
		end
	endgenerate

	// ********************
	// Derived clock enables
	// ********************
	// The CPU rate is an enable pulse, not a gated clock, so both domains share one edge.
	dzcg_divider dzcg_divider_i (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.slow_in(slowen_r),
		.ratio_in(ratio_r),
		.tick_out(cpu_tick)
	);

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			CPU_CE_OUT <= 1'b0;
		end else begin
			CPU_CE_OUT <= cpu_tick;
		end
	end

	// Peripherals never see the divided rate; only the CPU enable is slowed.
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			PERIPH_CE_OUT <= 1'b0;
		end else begin
			PERIPH_CE_OUT <= 1'b1;
		end
	end

	// ********************
	// Fast oscillator postscaler
	// ********************
	// The counter does not restart on a new code, so the first period after a write may differ.
	assign postscale_limit = 8'((9'h001 << postscale_r) - 9'h001);
	assign postscale_wrap = postscale_cnt_r >= postscale_limit;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN || postscale_wrap) begin
			postscale_cnt_r <= 8'h00;
		end else begin
			postscale_cnt_r <= postscale_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			OSC_CE_OUT <= 1'b0;
		end else begin
			OSC_CE_OUT <= postscale_wrap;
		end
	end

	// ********************
	// Read port
	// ********************
	assign ctrl_word = {recover_r, ratio_r, slowen_r, postscale_r,
		pll_out_div_r, 1'b0, pll_in_pre_r};
	assign gate_word = {8'h00, gate_r};
	assign status_word = {15'h0000, speed_r == dzcg_pkg::DZCG_SLOW};
	assign run_word = {8'h00, run_r};

	always_comb begin
		rd_word = 16'h0000;
		if (req.rd) begin
			unique case (req.addr)
				`DZCG_OFF_DIV_CTRL: rd_word = ctrl_word;
				`DZCG_OFF_GATE: rd_word = gate_word;
				`DZCG_OFF_STATUS: rd_word = status_word;
				`DZCG_OFF_PRESENT: rd_word = run_word;
				default: rd_word = 16'h0000;
			endcase
		end
	end

	// Idle cycles read zero, so a late sample of the read port cannot pass as data.
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			RDATA_OUT <= 16'h0000;
		end else begin
			RDATA_OUT <= rd_word;
		end
	end

endmodule
